// ===== rtl/rx_system_side_output.sv
// rx_system_side_output.sv: receive system-side output stage for the channels of a line interface.
// assumes the recovered clock and decoded line events arrive as pins asynchronous to clk_i,
// each event being a level held for one recovered clock period around that clock's rising edge.
// limitation: the line clock must stay high and low for two clk_i cycles or more each, and every
// event level must stand steady for two clk_i cycles around its rising edge, or an edge or a bit is lost.
// outputs trail the pin edge by three clk_i cycles; the recovered clock output moves on that same edge,
// so data and clock change together and a framer sampling on that edge has no setup margin for the bit.
`timescale 1ns/1ps
`include "rx_out_defs.svh"

module rx_system_side_output #(
    parameter int CHANNELS = `RXO_CHANNELS
) (
    input  wire logic                clk_i,                       // 200 MHz system clock
    input  wire logic                rst_i,                       // sync reset, high
    input  wire logic [CHANNELS-1:0] single_rail_mode_i,          // 1 = single-rail, static
    input  wire logic [CHANNELS-1:0] line_clock_i,                // recovered clock from clock recovery
    input  wire logic [CHANNELS-1:0] positive_pulse_i,            // positive pulse seen on line_input_pair
    input  wire logic [CHANNELS-1:0] negative_pulse_i,            // negative pulse seen on line_input_pair
    input  wire logic [CHANNELS-1:0] line_code_violation_i,       // decoder code violation
    input  wire logic [CHANNELS-1:0] excess_zero_event_i,         // decoder excess-zero event
    output logic      [CHANNELS-1:0] recovered_clock_out_o,       // recovered clock to framer
    output logic      [CHANNELS-1:0] positive_rail_data_out_o,    // positive rail / full data
    output logic      [CHANNELS-1:0] neg_rail_or_violation_out_o  // negative rail / violation
);
    localparam int SW = 6 * CHANNELS;

    logic [SW-1:0]       raw;
    logic [SW-1:0]       synced;
    logic [CHANNELS-1:0] clk_s;
    logic [CHANNELS-1:0] pos_s;
    logic [CHANNELS-1:0] neg_s;
    logic [CHANNELS-1:0] lcv_s;
    logic [CHANNELS-1:0] exz_s;
    logic [CHANNELS-1:0] mode_s;
    logic [CHANNELS-1:0] rise;
    logic [CHANNELS-1:0] next_neg;
    logic [CHANNELS-1:0] rail_mode;

    rx_out_pkg::clk_phase_t phase      [CHANNELS];
    rx_out_pkg::clk_phase_t next_phase [CHANNELS];

    initial begin
        if (CHANNELS < 1) begin
            $error("rx_system_side_output: CHANNELS must be at least 1");
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // an active edge is a high level seen while the tracker still holds the low phase
    function automatic logic edge_seen(
        input rx_out_pkg::clk_phase_t phase_now, // tracker state
        input logic                   level      // synchronised line clock
    );
        return (phase_now == rx_out_pkg::CLK_LOW) && level;
    endfunction : edge_seen

    // violation summary for single-rail mode; either event alone is enough
    function automatic logic violation_of(
        input logic line_code_violation, // code violation
        input logic excess_zero_event  // excess-zero event
    );
        return line_code_violation | excess_zero_event;
    endfunction : violation_of

    // source of the negative output for one channel
    function automatic logic neg_source(
        input logic single_mode, // synchronised rail mode
        input logic neg,         // negative-polarity data
        input logic line_code_violation,         // code violation
        input logic excess_zero_event          // excess-zero event
    );
        logic pick;
        if (single_mode == `RXO_MODE_SINGLE) begin
            pick = violation_of(line_code_violation, excess_zero_event);
        end else begin
            pick = neg;
        end
        return pick;
    endfunction : neg_source

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    // one bank for every input, so all six groups see exactly the same delay
    assign raw = {single_rail_mode_i, excess_zero_event_i, line_code_violation_i,
                  negative_pulse_i, positive_pulse_i, line_clock_i};

    rx_out_sync #(
        .WIDTH (SW)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (raw),
        .sync_o  (synced)
    );

    assign clk_s = synced[0*CHANNELS +: CHANNELS];
    assign pos_s = synced[1*CHANNELS +: CHANNELS];
    assign neg_s = synced[2*CHANNELS +: CHANNELS];
    assign lcv_s = synced[3*CHANNELS +: CHANNELS];
    assign exz_s = synced[4*CHANNELS +: CHANNELS];
    assign mode_s = synced[5*CHANNELS +: CHANNELS];

    // ------------------------------------------------------------
    // active edge detection
    // ------------------------------------------------------------
    // per-channel phase tracker; its reset state matches the idle low level of the line clock,
    // so releasing reset cannot fake an edge
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            next_phase[c] = phase[c];
            case (phase[c])
                rx_out_pkg::CLK_LOW: begin
                    if (clk_s[c]) begin
                        next_phase[c] = rx_out_pkg::CLK_HIGH;
                    end
                end
                rx_out_pkg::CLK_HIGH: begin
                    if (!clk_s[c]) begin
                        next_phase[c] = rx_out_pkg::CLK_LOW;
                    end
                end
                default: begin
                    next_phase[c] = rx_out_pkg::CLK_LOW;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < CHANNELS; c++) begin
            if (rst_i) begin
                phase[c] <= rx_out_pkg::CLK_LOW;
            end else begin
                phase[c] <= next_phase[c];
            end
        end
    end

    // rising edge is the launch edge; data and clock share the same sync delay so alignment holds
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            rise[c] = edge_seen(phase[c], clk_s[c]);
        end
    end

    // mode treated as static; a change takes effect at the next active edge, never mid-period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rail_mode <= '0;
        end else begin
            rail_mode <= mode_s;
        end
    end

    // ------------------------------------------------------------
    // recovered clock output
    // ------------------------------------------------------------
    // registered from the same synchronised level as the tracker, so it rises on the very clk_i edge
    // that launches the data; one more stage would let the data move ahead of its own clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            recovered_clock_out_o <= '0;
        end else begin
            recovered_clock_out_o <= clk_s;
        end
    end

    // ------------------------------------------------------------
    // rail mux
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            next_neg[c] = neg_source(rail_mode[c], neg_s[c], lcv_s[c], exz_s[c]);
        end
    end

    // ------------------------------------------------------------
    // positive output
    // ------------------------------------------------------------
    // data outputs hold between active edges, so each value lasts one full recovered period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            positive_rail_data_out_o <= {CHANNELS{`RXO_OUT_RESET}};
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (rise[c]) begin
                    positive_rail_data_out_o[c] <= pos_s[c];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // negative or violation output
    // ------------------------------------------------------------
    // a violation seen in one period shows for exactly that period, which meets the one-period minimum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            neg_rail_or_violation_out_o <= {CHANNELS{`RXO_OUT_RESET}};
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (rise[c]) begin
                    neg_rail_or_violation_out_o[c] <= next_neg[c];
                end
            end
        end
    end
endmodule : rx_system_side_output

// ===== include/rx_out_defs.svh
// rx_out_defs.svh: constants for the receive system-side output stage.
// assumes nothing; definitions only.
`ifndef RX_OUT_DEFS_SVH
`define RX_OUT_DEFS_SVH

// ------------------------------------------------------------
// mode encoding, reset values, synchroniser depth and channel count
// ------------------------------------------------------------
`define RXO_MODE_DUAL    1'b0
`define RXO_MODE_SINGLE  1'b1
`define RXO_OUT_RESET    1'b0
`define RXO_SYNC_STAGES  2
`define RXO_CHANNELS     12

`endif

// ===== include/rx_out_pkg.sv
// rx_out_pkg.sv: types for the receive system-side output stage.
// assumes rx_out_defs.svh holds the numeric constants.
package rx_out_pkg;

    // ------------------------------------------------------------
    // edge tracker state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_LOW,
        CLK_HIGH
    } clk_phase_t;

endpackage : rx_out_pkg

// ===== rtl/rx_out_sync.sv
// rx_out_sync.sv: two-flop synchroniser bank for inputs from the recovered clock domain.
// assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`include "rx_out_defs.svh"

module rx_out_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             rst_i,   // sync reset, high
    input  wire logic [WIDTH-1:0] async_i, // unsynchronised inputs
    output logic      [WIDTH-1:0] sync_o   // synchronised outputs
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("rx_out_sync: WIDTH must be at least 1");
        end
    end

    // first stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : rx_out_sync

// ===== bench/rx_out_props.sv
// rx_out_props.sv: port assertions for the receive output stage.
// assumes it is bound to rx_system_side_output with at least two lines.
`timescale 1ns/1ps
module rx_out_props #(
    parameter int CHANNELS = 12
) (
    input wire logic                clk_i,                      // clock
    input wire logic                rst_i,                      // reset
    input wire logic [CHANNELS-1:0] single_rail_mode_i,         // mode
    input wire logic [CHANNELS-1:0] line_clock_i,               // line clock
    input wire logic [CHANNELS-1:0] positive_pulse_i,           // pos in
    input wire logic [CHANNELS-1:0] negative_pulse_i,           // neg in
    input wire logic [CHANNELS-1:0] line_code_violation_i,      // lcv in
    input wire logic [CHANNELS-1:0] excess_zero_event_i,        // exz in
    input wire logic [CHANNELS-1:0] recovered_clock_out_o,      // clock out
    input wire logic [CHANNELS-1:0] positive_rail_data_out_o,   // pos out
    input wire logic [CHANNELS-1:0] neg_rail_or_violation_out_o // neg out
);
    wire [1:0] rc = recovered_clock_out_o[1:0];
    wire [1:0] po = positive_rail_data_out_o[1:0];
    wire [1:0] no = neg_rail_or_violation_out_o[1:0];
    wire [1:0] vi = line_code_violation_i[1:0] | excess_zero_event_i[1:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_up0; $rose(rc[0]); endsequence
    sequence s_up1; $rose(rc[1]); endsequence
    a_clock_rise: assert property ($rose(line_clock_i[0]) |-> ##3 s_up0)
        else $error("recovered clock rise late");
    a_clock_fall: assert property ($fell(line_clock_i[1]) |-> ##3 $fell(rc[1]))
        else $error("recovered clock fall late");
    a_dual_neg: assert property (!single_rail_mode_i[0] ##0 s_up0 |-> no[0] == $past(negative_pulse_i[0], 2))
        else $error("negative rail wrong");
    a_dual_pos: assert property (!single_rail_mode_i[0] ##0 s_up0 |-> po[0] == $past(positive_pulse_i[0], 2))
        else $error("positive rail wrong");
    a_single_viol: assert property (single_rail_mode_i[1] ##0 s_up1 |-> no[1] == $past(vi[1], 2))
        else $error("violation output wrong");
    a_single_data: assert property (single_rail_mode_i[1] ##0 s_up1 |-> po[1] == $past(positive_pulse_i[1], 2))
        else $error("single rail data wrong");
    a_hold_dual: assert property (!$rose(rc[0]) |-> $stable({po[0], no[0]}))
        else $error("dual outputs moved off edge");
    a_hold_single: assert property (!$rose(rc[1]) |-> $stable({po[1], no[1]}))
        else $error("single outputs moved off edge");
endmodule : rx_out_props

// ===== bench/rx_framer_model.sv
// rx_framer_model.sv: downstream framer capturing both rails of two lines.
// assumes the recovered clock is far slower than clk_i.
`timescale 1ns/1ps
module rx_framer_model (
    input  wire logic       clk_i,   // system clock
    input  wire logic [1:0] clock_i, // recovered clocks
    input  wire logic [1:0] pos_i,   // positive rail
    input  wire logic [1:0] neg_i,   // negative rail or violation
    output logic      [1:0] pos_o,   // captured positive
    output logic      [1:0] neg_o    // captured negative
);
    logic [1:0] clock_seen = 2'h0;
    always_ff @(posedge clk_i) begin
        clock_seen <= clock_i;
        for (int c = 0; c < 2; c++) begin
            if (clock_i[c] && !clock_seen[c]) begin
                pos_o[c] <= pos_i[c];
                neg_o[c] <= neg_i[c];
            end
        end
    end
endmodule : rx_framer_model

// ===== bench/rx_system_side_output_bench.sv
// rx_system_side_output_bench.sv: bench with line 0 dual-rail and line 1 single-rail.
// assumes the design, rx_out_props and rx_framer_model are compiled first.
`timescale 1ns/1ps
module rx_system_side_output_bench;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [1:0] mode = 2'h2, lclk = 2'h0, pos = 2'h0, neg = 2'h0, line_code_violation = 2'h0, excess_zero_event = 2'h0;
    logic [1:0] rco, pos_o, neg_o, cap_pos, cap_neg;
    int         fail_count = 0;
    int         total_checks = 0;
    always #2.5 clk_i = ~clk_i;
    rx_system_side_output #(.CHANNELS(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .single_rail_mode_i(mode),
        .line_clock_i(lclk), .positive_pulse_i(pos), .negative_pulse_i(neg), .line_code_violation_i(line_code_violation),
        .excess_zero_event_i(excess_zero_event), .recovered_clock_out_o(rco), .positive_rail_data_out_o(pos_o),
        .neg_rail_or_violation_out_o(neg_o));
    rx_framer_model u_framer (.clk_i(clk_i), .clock_i(rco), .pos_i(pos_o), .neg_i(neg_o),
        .pos_o(cap_pos), .neg_o(cap_neg));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // one 125 ns line period; data held across the whole high phase
    task automatic step(input logic [7:0] v, input logic [3:0] exp);
        @(posedge clk_i);
        {pos, neg, line_code_violation, excess_zero_event} <= v;
        lclk <= 2'h0;
        repeat (12) @(posedge clk_i);
        lclk <= 2'h3;
        repeat (12) @(posedge clk_i);
        total_checks++;
        if ({cap_pos, cap_neg} !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, {cap_pos, cap_neg}, exp);
        end
    endtask : step
    task automatic test_dual;
        step(8'h40, 4'h4);
        step(8'h10, 4'h1);
        step(8'h10, 4'h1);
        step(8'h05, 4'h0);
        $display("test_dual done");
    endtask : test_dual
    task automatic test_single;
        step(8'h88, 4'hA);
        step(8'h02, 4'h2);
        step(8'h20, 4'h0);
        step(8'h80, 4'h8);
        $display("test_single done");
    endtask : test_single
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_dual();
        test_single();
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
endmodule : rx_system_side_output_bench
bind rx_system_side_output rx_out_props #(.CHANNELS(CHANNELS)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .single_rail_mode_i(single_rail_mode_i), .line_clock_i(line_clock_i), .positive_pulse_i(positive_pulse_i),
    .negative_pulse_i(negative_pulse_i), .line_code_violation_i(line_code_violation_i),
    .excess_zero_event_i(excess_zero_event_i), .recovered_clock_out_o(recovered_clock_out_o),
    .positive_rail_data_out_o(positive_rail_data_out_o), .neg_rail_or_violation_out_o(neg_rail_or_violation_out_o));
